// [rsf_failover.sv]
// Functional notes
// - Pressure pair differing over threshold for full delay marks lower one failed.
// - Issue-flow pair differing over threshold after delay marks lower one failed.
// - Return-flow pair differing over threshold after delay marks lower one failed.
// - Controller receives both sensor sets and drives outputs through its own rack.
// - Primary controls with first set plus operator set-point changes normally.
// - Standby keeps monitoring first-set inputs while the primary is in control.
// - Failed first-set input is replaced by second set and alarmed.
// - Control passes to standby on primary handover or detected primary fault.
// - Standby in control annunciates, applies set-points, defaults to first set.
// - Standby in control swaps any faulty first-set input for its second-set twin.
// - First-set power lost with standby in control selects all second-set inputs.
// - Standby reports own faults to primary; primary reports standby faults.
// - Operator selector on second set makes both controllers use second set.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module rsf_failover
  import rsf_pkg::*;
#(
  parameter int DELAY_CYCLES = RSF_DELAY_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [RSF_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RSF_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rsf_pair_t pressurePair,
  input wire rsf_pair_t issueFlowPair,
  input wire rsf_pair_t returnFlowPair,
  input wire logic selectorSecond,
  input wire logic firstSetPowerOk,
  input wire logic roleStandby,
  input wire logic peerFaultIn,
  input wire logic peerHandoverIn,
  output logic [RSF_NCH*RSF_RDG_W-1:0] selectedReadings,
  output logic [RSF_NCH-1:0] useSecondSet,
  output logic [RSF_RDG_W-1:0] setpointOut,
  output logic inControl,
  output logic handoverOut,
  output logic ownFaultOut,
  output logic peerFaultAlarm,
  output logic faultAnnunciate,
  output logic sensorFailAlarm
);
  localparam logic [31:0] DELAY_LAST = 32'(DELAY_CYCLES - 1);

  rsf_pair_t pairSync1_r [RSF_NCH];
  rsf_pair_t pairSync2_r [RSF_NCH];
  logic [4:0] pinSync1_r;
  logic [4:0] pinSync2_r;
  logic selSecond;
  logic powerLost;
  logic roleSync;
  logic peerFault;
  logic peerHandover;

  logic [RSF_RDG_W-1:0] thr_r [RSF_NCH];
  logic [RSF_RDG_W-1:0] setpoint_r;
  logic ownFault_r;
  logic clearPulse_r;
  logic [2*RSF_NCH-1:0] failed_r;
  logic [RSF_NCH-1:0] useSecond;

  rsf_ctl_t ctl_r;
  rsf_ctl_t ctl_nxt;
  logic roleStandby_r;
  logic [1:0] strapCnt_r;

  logic awHeld_r;
  logic wHeld_r;
  logic [RSF_AXI_AW-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic [31:0] rdWord;
  logic rdHit;
  logic wrHit;
  logic doWrite;

  // Field readings are asynchronous to mclk; each word settles slowly enough
  // that a two-stage capture is adequate for a comparison over seconds.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < RSF_NCH; i++) begin
        pairSync1_r[i] <= '0;
        pairSync2_r[i] <= '0;
      end
      pinSync1_r <= 5'h00;
      pinSync2_r <= 5'h00;
    end else if (ce) begin
      pairSync1_r[0] <= pressurePair;
      pairSync1_r[1] <= issueFlowPair;
      pairSync1_r[2] <= returnFlowPair;
      pairSync2_r <= pairSync1_r;
      pinSync1_r <= {peerHandoverIn, peerFaultIn, roleStandby, ~firstSetPowerOk, selectorSecond};
      pinSync2_r <= pinSync1_r;
    end
  end

  assign selSecond = pinSync2_r[0];
  assign powerLost = pinSync2_r[1];
  assign roleSync = pinSync2_r[2];
  assign peerFault = pinSync2_r[3];
  assign peerHandover = pinSync2_r[4];

  // The role strap is taken once, after the synchroniser has filled.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strapCnt_r <= 2'h0;
      roleStandby_r <= 1'b0;
    end else if (ce && strapCnt_r != RSF_STRAP_SETTLE) begin
      strapCnt_r <= strapCnt_r + 2'h1;
      roleStandby_r <= roleSync;
    end
  end

  // Per channel: disagreement timer and latched failure of the lower reading.
  genvar g;
  generate
    for (g = 0; g < RSF_NCH; g++) begin : gChan
      logic [RSF_RDG_W-1:0] rdA;
      logic [RSF_RDG_W-1:0] rdB;
      logic [RSF_RDG_W-1:0] diff;
      logic over;
      logic expire;
      logic [31:0] cnt_r;

      assign rdA = pairSync2_r[g].setA;
      assign rdB = pairSync2_r[g].setB;
      assign diff = (rdA > rdB) ? rdA - rdB : rdB - rdA;
      assign over = diff > thr_r[g];
      assign expire = over && cnt_r == DELAY_LAST;

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          cnt_r <= 32'h0;
        end else if (ce) begin
          if (!over) begin
            cnt_r <= 32'h0;
          end else if (cnt_r != DELAY_LAST) begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
      end

      // A new failure in the clearing cycle wins over the clear.
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          failed_r[2*g+1:2*g] <= 2'b00;
        end else if (ce) begin
          if (expire) begin
            failed_r[2*g] <= failed_r[2*g] | (rdA < rdB);
            failed_r[2*g+1] <= failed_r[2*g+1] | (rdB < rdA);
          end else if (clearPulse_r) begin
            failed_r[2*g+1:2*g] <= 2'b00;
          end
        end
      end

      // Both controllers run this comparison, so the standby keeps watching too.
      assign useSecond[g] = failed_r[2*g]
        | selSecond
        | (roleStandby_r && ctl_r == CTL_ACTIVE && powerLost);

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          selectedReadings[g*RSF_RDG_W +: RSF_RDG_W] <= '0;
          useSecondSet[g] <= 1'b0;
        end else if (ce) begin
          selectedReadings[g*RSF_RDG_W +: RSF_RDG_W] <= useSecond[g] ? rdB : rdA;
          useSecondSet[g] <= useSecond[g];
        end
      end
    end
  endgenerate

  // Controller role and handover.
  always_comb begin
    ctl_nxt = ctl_r;
    case (ctl_r)
      CTL_STRAP: begin
        if (strapCnt_r == RSF_STRAP_SETTLE) begin
          ctl_nxt = roleStandby_r ? CTL_STANDBY : CTL_ACTIVE;
        end
      end
      CTL_ACTIVE: begin
        if (!roleStandby_r && ownFault_r) begin
          ctl_nxt = CTL_RELEASED;
        end else if (roleStandby_r && clearPulse_r && !peerFault && !peerHandover) begin
          ctl_nxt = CTL_STANDBY;
        end
      end
      CTL_STANDBY: begin
        if (peerHandover || peerFault) begin
          ctl_nxt = CTL_ACTIVE;
        end
      end
      CTL_RELEASED: begin
        if (clearPulse_r && !ownFault_r) begin
          ctl_nxt = CTL_ACTIVE;
        end
      end
      default: begin
        ctl_nxt = CTL_STRAP;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= CTL_STRAP;
    end else if (ce) begin
      ctl_r <= ctl_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      inControl <= 1'b0;
      handoverOut <= 1'b0;
      ownFaultOut <= 1'b0;
      peerFaultAlarm <= 1'b0;
      faultAnnunciate <= 1'b0;
      sensorFailAlarm <= 1'b0;
      setpointOut <= RSF_SETPT_RST;
    end else if (ce) begin
      inControl <= ctl_nxt == CTL_ACTIVE;
      handoverOut <= ctl_nxt == CTL_RELEASED;
      ownFaultOut <= ownFault_r;
      peerFaultAlarm <= peerFault;
      faultAnnunciate <= roleStandby_r && ctl_nxt == CTL_ACTIVE;
      sensorFailAlarm <= |failed_r;
      if (ctl_r == CTL_ACTIVE) begin
        setpointOut <= setpoint_r;
      end
    end
  end

  // Register file, AXI4-Lite write side. Address and data are taken in
  // either order; the response goes out once both are held.
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_comb begin
    case (awAddr_r)
      RSF_OFF_CTRL, RSF_OFF_PTHR, RSF_OFF_ITHR, RSF_OFF_RTHR, RSF_OFF_SETPT, RSF_OFF_STATUS: begin
        wrHit = 1'b1;
      end
      default: begin
        wrHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RSF_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RSF_RESP_OKAY : RSF_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Only the low two byte lanes carry register bits; upper lanes are ignored.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      thr_r[0] <= RSF_PTHR_RST;
      thr_r[1] <= RSF_ITHR_RST;
      thr_r[2] <= RSF_RTHR_RST;
      setpoint_r <= RSF_SETPT_RST;
      ownFault_r <= 1'b0;
      clearPulse_r <= 1'b0;
    end else if (ce) begin
      clearPulse_r <= 1'b0;
      if (doWrite) begin
        for (int b = 0; b < 2; b++) begin
          if (wStrb_r[b]) begin
            case (awAddr_r)
              RSF_OFF_PTHR: thr_r[0][8*b +: 8] <= wData_r[8*b +: 8];
              RSF_OFF_ITHR: thr_r[1][8*b +: 8] <= wData_r[8*b +: 8];
              RSF_OFF_RTHR: thr_r[2][8*b +: 8] <= wData_r[8*b +: 8];
              RSF_OFF_SETPT: setpoint_r[8*b +: 8] <= wData_r[8*b +: 8];
              default: begin
              end
            endcase
          end
        end
        if (awAddr_r == RSF_OFF_CTRL && wStrb_r[0]) begin
          clearPulse_r <= wData_r[RSF_CTRL_CLEAR_BIT];
          ownFault_r <= wData_r[RSF_CTRL_OWNFLT_BIT];
        end
      end
    end
  end

  // Read side.
  always_comb begin
    rdWord = 32'h0;
    rdHit = 1'b1;
    case (s_axi_araddr)
      RSF_OFF_CTRL: rdWord[RSF_CTRL_OWNFLT_BIT] = ownFault_r;
      RSF_OFF_PTHR: rdWord[RSF_RDG_W-1:0] = thr_r[0];
      RSF_OFF_ITHR: rdWord[RSF_RDG_W-1:0] = thr_r[1];
      RSF_OFF_RTHR: rdWord[RSF_RDG_W-1:0] = thr_r[2];
      RSF_OFF_SETPT: rdWord[RSF_RDG_W-1:0] = setpoint_r;
      RSF_OFF_STATUS: rdWord[15:0] = {ctl_r, selSecond, powerLost, peerFault, roleStandby_r,
                                       ctl_r == CTL_ACTIVE, useSecond, failed_r};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RSF_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdHit ? RSF_RESP_OKAY : RSF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [rsf_failover_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module rsf_failover_monitor
  import rsf_pkg::*;
#(
  parameter int DELAY_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic s_axi_bvalid,
  input wire rsf_pair_t pressurePair,
  input wire rsf_pair_t issueFlowPair,
  input wire rsf_pair_t returnFlowPair,
  input wire logic selectorSecond,
  input wire logic firstSetPowerOk,
  input wire logic roleStandby,
  input wire logic peerFaultIn,
  input wire logic peerHandoverIn,
  input wire logic [RSF_NCH-1:0] useSecondSet,
  input wire logic inControl,
  input wire logic handoverOut,
  input wire logic ownFaultOut,
  input wire logic peerFaultAlarm,
  input wire logic faultAnnunciate,
  input wire logic sensorFailAlarm
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic anyDiff;
  int diffCnt_r;
  // Over threshold implies the pair differs, so a new mark needs a full delay of unbroken disagreement.
  // Readings may still move while they disagree, which is why stillness is not required.
  assign anyDiff = (pressurePair.setA != pressurePair.setB) || (issueFlowPair.setA != issueFlowPair.setB)
    || (returnFlowPair.setA != returnFlowPair.setB);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      diffCnt_r <= 0;
    end else begin
      diffCnt_r <= anyDiff ? diffCnt_r + 1 : 0;
    end
  end
  chk_fail_delay: assert property ($rose(sensorFailAlarm) |-> diffCnt_r >= DELAY_CYCLES)
    else $error("failure mark before delay");
  chk_mark_latch: assert property ($fell(sensorFailAlarm) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("failure mark dropped without clear");
  chk_sel_second: assert property (selectorSecond [*5] |-> useSecondSet == 3'h7)
    else $error("selector ignored");
  chk_power_lost: assert property ((roleStandby && inControl && !firstSetPowerOk) [*5] |-> useSecondSet == 3'h7)
    else $error("power loss ignored");
  chk_first_use: assert property ((!selectorSecond && !sensorFailAlarm && firstSetPowerOk) [*5] |-> useSecondSet == 3'h0)
    else $error("second set used without cause");
  chk_peer_fault: assert property ($stable(peerFaultIn) [*4] |-> peerFaultAlarm == peerFaultIn)
    else $error("peer fault not reported");
  chk_own_handover: assert property (!roleStandby && ownFaultOut |-> ##[0:4] handoverOut)
    else $error("no handover on own fault");
  chk_primary_run: assert property ((!roleStandby && !handoverOut) [*8] |-> inControl)
    else $error("primary not in control");
  chk_standby_take: assert property ((roleStandby && peerHandoverIn) [*8] |-> inControl)
    else $error("standby did not take over");
  chk_annunciate: assert property ($rose(inControl) |-> ##[0:1] faultAnnunciate == roleStandby)
    else $error("annunciation wrong");
  cover property ($rose(sensorFailAlarm));
  cover property ($rose(handoverOut));
  cover property ($rose(faultAnnunciate));
endmodule
bind rsf_failover rsf_failover_monitor #(.DELAY_CYCLES(DELAY_CYCLES)) mon (.mclk(mclk), .rstn(rstn),
  .s_axi_bvalid(s_axi_bvalid), .pressurePair(pressurePair), .issueFlowPair(issueFlowPair),
  .returnFlowPair(returnFlowPair), .selectorSecond(selectorSecond), .firstSetPowerOk(firstSetPowerOk),
  .roleStandby(roleStandby), .peerFaultIn(peerFaultIn), .peerHandoverIn(peerHandoverIn),
  .useSecondSet(useSecondSet), .inControl(inControl), .handoverOut(handoverOut), .ownFaultOut(ownFaultOut),
  .peerFaultAlarm(peerFaultAlarm), .faultAnnunciate(faultAnnunciate), .sensorFailAlarm(sensorFailAlarm));
`default_nettype wire

// [rsf_field_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rsf_field_model
  import rsf_pkg::*;
(
  input wire logic mclk,
  input wire logic [47:0] valA,
  input wire logic [47:0] valB,
  input wire logic powerOk,
  input wire logic selReq,
  output rsf_pair_t pressurePair,
  output rsf_pair_t issueFlowPair,
  output rsf_pair_t returnFlowPair,
  output logic firstSetPowerOk,
  output logic selectorSecond
);
  logic [47:0] firstSet;
  // An unpowered transmitter reads junk; inverting each cycle keeps a stale value from looking healthy.
  always_ff @(posedge mclk) begin
    firstSet <= powerOk ? valA : ~firstSet;
    firstSetPowerOk <= powerOk;
    selectorSecond <= selReq;
  end
  assign pressurePair = {firstSet[15:0], valB[15:0]};
  assign issueFlowPair = {firstSet[31:16], valB[31:16]};
  assign returnFlowPair = {firstSet[47:32], valB[47:32]};
endmodule
`default_nettype wire

// [rsf_pkg.sv]
`default_nettype none
package rsf_pkg;
  localparam int RSF_RDG_W = 16;
  localparam int RSF_NCH = 3;
  localparam int RSF_AXI_AW = 8;

  localparam logic [RSF_AXI_AW-1:0] RSF_OFF_CTRL = 8'h00;
  localparam logic [RSF_AXI_AW-1:0] RSF_OFF_PTHR = 8'h04;
  localparam logic [RSF_AXI_AW-1:0] RSF_OFF_ITHR = 8'h08;
  localparam logic [RSF_AXI_AW-1:0] RSF_OFF_RTHR = 8'h0c;
  localparam logic [RSF_AXI_AW-1:0] RSF_OFF_SETPT = 8'h10;
  localparam logic [RSF_AXI_AW-1:0] RSF_OFF_STATUS = 8'h14;

  localparam int RSF_CTRL_CLEAR_BIT = 0;
  localparam int RSF_CTRL_OWNFLT_BIT = 1;

  // Pressure in 1 kPa steps, flows in 0.1 L/s steps.
  localparam logic [RSF_RDG_W-1:0] RSF_PTHR_RST = 16'h0046;
  localparam logic [RSF_RDG_W-1:0] RSF_ITHR_RST = 16'h0014;
  localparam logic [RSF_RDG_W-1:0] RSF_RTHR_RST = 16'h000c;
  localparam logic [RSF_RDG_W-1:0] RSF_SETPT_RST = 16'h0000;

  localparam int RSF_DELAY_S = 10;
  localparam int RSF_CLK_HZ = 100_000_000;
  localparam int RSF_DELAY_CYC = RSF_DELAY_S * RSF_CLK_HZ;

  localparam logic [1:0] RSF_RESP_OKAY = 2'b00;
  localparam logic [1:0] RSF_RESP_SLVERR = 2'b10;
  // Three edges: two to fill the pin synchroniser, one to take the filled value.
  localparam logic [1:0] RSF_STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic [RSF_RDG_W-1:0] setA;
    logic [RSF_RDG_W-1:0] setB;
  } rsf_pair_t;

  typedef enum logic [1:0] {
    CTL_STRAP = 2'b00,
    CTL_ACTIVE = 2'b01,
    CTL_STANDBY = 2'b10,
    CTL_RELEASED = 2'b11
  } rsf_ctl_t;
endpackage
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rsf_pkg::*;
;
  localparam int DLY = 20;
  logic mclk, rstn, ce, roleStandby, peerFaultIn, peerHandoverIn, powerOk, selReq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic inCtl, hand, ownF, peerAl, annun, sensAl, pwrOk, selSec;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] useB;
  logic [15:0] setpt;
  logic [47:0] valA, valB, rdg;
  rsf_pair_t pP, iP, rP;
  int err_total, n_compared;
  rsf_field_model field (.mclk(mclk), .valA(valA), .valB(valB), .powerOk(powerOk), .selReq(selReq),
    .pressurePair(pP), .issueFlowPair(iP), .returnFlowPair(rP), .firstSetPowerOk(pwrOk), .selectorSecond(selSec));
  rsf_failover #(.DELAY_CYCLES(DLY)) dut (.mclk(mclk), .rstn(rstn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pressurePair(pP), .issueFlowPair(iP), .returnFlowPair(rP), .selectorSecond(selSec),
    .firstSetPowerOk(pwrOk), .roleStandby(roleStandby), .peerFaultIn(peerFaultIn),
    .peerHandoverIn(peerHandoverIn), .selectedReadings(rdg), .useSecondSet(useB), .setpointOut(setpt),
    .inControl(inCtl), .handoverOut(hand), .ownFaultOut(ownF), .peerFaultAlarm(peerAl),
    .faultAnnunciate(annun), .sensorFailAlarm(sensAl));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic do_reset(input logic standby);
    rstn <= 1'b0;
    roleStandby <= standby;
    wt(3);
    rstn <= 1'b1;
    wt(8);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got;
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    got = 0;
    n = 0;
    while (!got && n < 40) begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        check("bresp", bresp, er);
        got = 1;
      end
    end
    bready <= 1'b0;
    check("write answered", got, 1'b1);
    @(posedge mclk);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit got;
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    got = 0;
    n = 0;
    while (!got && n < 40) begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        check("rdata", rdata, ed);
        check("rresp", rresp, er);
        got = 1;
      end
    end
    rready <= 1'b0;
    check("read answered", got, 1'b1);
    @(posedge mclk);
  endtask
  // Readings must settle through the input synchronisers before a clear, or the still-expiring timer wins over the clear and the mark stays.
  task automatic clr();
    wt(3);
    axw(RSF_OFF_CTRL, 32'h1, RSF_RESP_OKAY);
    wt(4);
  endtask
  task automatic t_regs();
    axr(RSF_OFF_CTRL, 32'h0, RSF_RESP_OKAY);
    axr(RSF_OFF_PTHR, 32'h46, RSF_RESP_OKAY);
    axr(RSF_OFF_ITHR, 32'h14, RSF_RESP_OKAY);
    axr(RSF_OFF_RTHR, 32'hc, RSF_RESP_OKAY);
    axr(8'h18, 32'h0, RSF_RESP_SLVERR);
    axw(8'h18, 32'h1, RSF_RESP_SLVERR);
  endtask
  task automatic t_press();
    {valA, valB} <= {48'h64, 48'haa};
    wt(DLY + 10);
    check("alarm at threshold", sensAl, 1'b0);
    valB <= 48'hab;
    wt(DLY - 5);
    valB <= 48'h64;
    wt(1);
    valB <= 48'hab;
    wt(DLY - 5);
    check("alarm after break", sensAl, 1'b0);
    wt(12);
    check("pressure failed", {sensAl, useB, rdg[15:0]}, {1'b1, 3'b001, 16'hab});
    valB <= 48'h64;
    wt(DLY + 5);
    check("latched", useB, 3'b001);
    clr();
    check("cleared", {sensAl, useB}, 4'h0);
  endtask
  task automatic t_flows();
    {valA, valB} <= {48'h000a_0032_0064, 48'h0017_001d_0064};
    wt(DLY + 8);
    check("issue keeps first", {useB[1], rdg[31:16]}, {1'b0, 16'h32});
    check("return to second", {useB[2], rdg[47:32]}, {1'b1, 16'h17});
    valA <= 48'h0017_001d_0064;
    clr();
  endtask
  task automatic t_sel();
    {valA, valB} <= {48'h0003_0002_0001, 48'h0006_0005_0004};
    selReq <= 1'b1;
    wt(6);
    check("selector", {useB, rdg}, {3'b111, 48'h0006_0005_0004});
    selReq <= 1'b0;
    wt(6);
    check("first set", {useB, rdg}, {3'b000, 48'h0003_0002_0001});
  endtask
  task automatic t_primary();
    check("primary runs", {inCtl, annun, hand}, 3'b100);
    axw(RSF_OFF_SETPT, 32'h1234, RSF_RESP_OKAY);
    wt(2);
    check("set-point", setpt, 16'h1234);
    peerFaultIn <= 1'b1;
    wt(5);
    check("peer fault", peerAl, 1'b1);
    peerFaultIn <= 1'b0;
    axw(RSF_OFF_CTRL, 32'h2, RSF_RESP_OKAY);
    wt(5);
    check("handover", {inCtl, hand, ownF}, 3'b011);
    axw(RSF_OFF_CTRL, 32'h0, RSF_RESP_OKAY);
    clr();
    check("resumed", {inCtl, hand, ownF}, 3'b100);
  endtask
  task automatic t_standby();
    do_reset(1'b1);
    check("standby waits", {inCtl, annun}, 2'b00);
    axw(RSF_OFF_SETPT, 32'h777, RSF_RESP_OKAY);
    peerHandoverIn <= 1'b1;
    wt(6);
    check("takeover", {inCtl, annun, setpt, useB}, {2'b11, 16'h777, 3'b000});
    powerOk <= 1'b0;
    wt(6);
    check("power lost", {useB, rdg}, {3'b111, 48'h0006_0005_0004});
    powerOk <= 1'b1;
    valB <= 48'h0006_0005_0080;
    wt(DLY + 8);
    check("standby swaps input", useB, 3'b001);
  endtask
  initial begin
    {ce, powerOk, peerFaultIn, peerHandoverIn, selReq, awvalid, wvalid, bready, arvalid, rready} <= 10'h300;
    {awaddr, araddr, wdata, valA, valB} <= 144'h0;
    do_reset(1'b0);
    t_regs();
    t_press();
    t_flows();
    t_sel();
    t_primary();
    t_standby();
    give_verdict();
  end
  initial begin
    wt(3000);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
